// file: rtl/mmnx_params.svh
`ifndef MMNX_PARAMS_SVH
`define MMNX_PARAMS_SVH
// ----------------------------------------
// opcode patterns, upper bits of the word
// ----------------------------------------
`define MMNX_OP_MOVE_HI7 7'h37
`define MMNX_OP_NEG_HI7 7'h36
`define MMNX_OP_MULF_HI7 7'h01
`define MMNX_OP_MULL_HI8 8'h0d
// ----------------------------------------
// addressing
// ----------------------------------------
`define MMNX_INDEXED_MAX 8'h5f
`define MMNX_ACCESS_SPLIT 8'h60
`define MMNX_ACCESS_HIGH_BANK 4'hf
// ----------------------------------------
// status flag bit positions
// ----------------------------------------
`define MMNX_FLAG_C 0
`define MMNX_FLAG_DC 1
`define MMNX_FLAG_Z 2
`define MMNX_FLAG_OV 3
`define MMNX_FLAG_N 4
`define MMNX_STATUS_RESET 5'h00
`endif

// file: rtl/mmnx_pkg.sv
`default_nettype none
package mmnx_pkg;
    typedef enum logic [1:0] {
        MMNX_Q1 = 2'b00,
        MMNX_Q2 = 2'b01,
        MMNX_Q3 = 2'b10,
        MMNX_Q4 = 2'b11
    } mmnx_phase_t;
    typedef enum logic [2:0] {
        MMNX_NONE = 3'b000,
        MMNX_MOVE = 3'b001,
        MMNX_MULL = 3'b010,
        MMNX_MULF = 3'b011,
        MMNX_NEG = 3'b100
    } mmnx_op_t;
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } mmnx_mem_req_t;
endpackage
`default_nettype wire

// file: rtl/mmnx_mult.sv
`default_nettype none
// registered unsigned multiplier, result held until next load
module mmnx_mult #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic load,
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    output logic [2*W-1:0] product
);
    always_ff @(posedge clock) begin
        if (srst) begin
            product <= '0;
        end else if (clk_en && load) begin
            product <= a * b; // unsigned: no overflow possible
        end
    end
endmodule
`default_nettype wire

// file: rtl/mmnx_exec.sv
`include "mmnx_params.svh"
`default_nettype none
module mmnx_exec
    import mmnx_pkg::*;
#(
    parameter int DW = 8
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [DW-1:0] acc,
    input wire logic [3:0] bank_select_reg,
    input wire logic ext_set_en,
    input wire logic [11:0] index_base,
    input wire logic [DW-1:0] mem_rdata,
    output logic busy,
    output logic done,
    output logic unsupported,
    output mmnx_mem_req_t mem_req,
    output logic [DW-1:0] product_high_byte,
    output logic [DW-1:0] product_low_byte,
    output logic product_we,
    output logic [4:0] status_flags,
    output logic [4:0] status_we
);
    // ----------------------------------------
    // decode
    // ----------------------------------------
    mmnx_op_t op_dec, op_reg;
    mmnx_phase_t phase_reg;
    logic [7:0] lit_reg;
    logic [DW-1:0] acc_reg, opnd_reg, neg_res;
    logic [11:0] addr_next;
    logic mul_load;
    logic [2*DW-1:0] prod;

    always_comb begin
        op_dec = MMNX_NONE;
        if (instr_word[15:9] == `MMNX_OP_MOVE_HI7) op_dec = MMNX_MOVE;
        else if (instr_word[15:9] == `MMNX_OP_NEG_HI7) op_dec = MMNX_NEG;
        else if (instr_word[15:9] == `MMNX_OP_MULF_HI7) op_dec = MMNX_MULF;
        else if (instr_word[15:8] == `MMNX_OP_MULL_HI8) op_dec = MMNX_MULL;
    end

    // bank bit clear uses access bank (index_base + offset when ext_set_en and offset <= 0x5f); split low/high at 0x60
    always_comb begin
        if (instr_word[8]) begin
            addr_next = {bank_select_reg, instr_word[7:0]};
        end else if (ext_set_en && instr_word[7:0] <= `MMNX_INDEXED_MAX) begin
            addr_next = index_base + {4'h0, instr_word[7:0]};
        end else if (instr_word[7:0] < `MMNX_ACCESS_SPLIT) begin
            addr_next = {4'h0, instr_word[7:0]};
        end else begin
            addr_next = {`MMNX_ACCESS_HIGH_BANK, instr_word[7:0]};
        end
    end

    // ----------------------------------------
    // phase sequencer
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            phase_reg <= MMNX_Q1;
            busy <= 1'b0;
            op_reg <= MMNX_NONE;
        end else if (clk_en) begin
            case (phase_reg)
                MMNX_Q1: begin
                    if (instr_valid && op_dec != MMNX_NONE) begin
                        phase_reg <= MMNX_Q2;
                        busy <= 1'b1;
                        op_reg <= op_dec;
                    end
                end
                MMNX_Q2: phase_reg <= MMNX_Q3;
                MMNX_Q3: phase_reg <= MMNX_Q4;
                MMNX_Q4: begin
                    phase_reg <= MMNX_Q1;
                    busy <= 1'b0;
                end
                default: phase_reg <= MMNX_Q1;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            unsupported <= 1'b0;
        end else if (clk_en) begin
            unsupported <= phase_reg == MMNX_Q1 && instr_valid && op_dec == MMNX_NONE;
        end
    end

    // ----------------------------------------
    // operand capture
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            lit_reg <= 8'h00;
            acc_reg <= '0;
            mem_req <= '0;
        end else if (clk_en) begin
            mem_req.re <= 1'b0;
            mem_req.we <= 1'b0;
            if (phase_reg == MMNX_Q1 && instr_valid && op_dec != MMNX_NONE) begin
                lit_reg <= instr_word[7:0];
                acc_reg <= acc;
                mem_req.addr <= addr_next;
                mem_req.re <= op_dec == MMNX_NEG || op_dec == MMNX_MULF;
            end
            if (phase_reg == MMNX_Q3 && (op_reg == MMNX_MOVE || op_reg == MMNX_NEG)) begin
                mem_req.we <= 1'b1; // lands during the final phase
                mem_req.wdata <= (op_reg == MMNX_MOVE) ? acc_reg : neg_res;
            end
        end
    end

    // read data sampled in the same cycle the read strobe is high
    always_ff @(posedge clock) begin
        if (srst) begin
            opnd_reg <= '0;
        end else if (clk_en && phase_reg == MMNX_Q2) begin
            opnd_reg <= (op_reg == MMNX_MULL) ? lit_reg : mem_rdata;
        end
    end

    assign neg_res = ~opnd_reg + 8'h01;

    // ----------------------------------------
    // multiply
    // ----------------------------------------
    assign mul_load = phase_reg == MMNX_Q3 && (op_reg == MMNX_MULL || op_reg == MMNX_MULF);

    mmnx_mult #(.W(DW)) u_mult (
        .clock(clock),
        .srst(srst),
        .clk_en(clk_en),
        .load(mul_load),
        .a(acc_reg),
        .b(opnd_reg),
        .product(prod)
    );

    // product written into pair, high byte upper
    assign product_high_byte = prod[2*DW-1:DW];
    assign product_low_byte = prod[DW-1:0];

    always_ff @(posedge clock) begin
        if (srst) begin
            product_we <= 1'b0;
            done <= 1'b0;
        end else if (clk_en) begin
            product_we <= mul_load;
            done <= phase_reg == MMNX_Q3;
        end
    end

    // ----------------------------------------
    // flags: only negate writes them
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            status_flags <= `MMNX_STATUS_RESET;
            status_we <= 5'h00;
        end else if (clk_en) begin
            status_we <= 5'h00; // multiply and move leave flags
            if (phase_reg == MMNX_Q3 && op_reg == MMNX_NEG) begin
                status_we <= 5'h1f;
                status_flags[`MMNX_FLAG_N] <= neg_res[DW-1];
                status_flags[`MMNX_FLAG_Z] <= neg_res == '0;
                status_flags[`MMNX_FLAG_C] <= opnd_reg == '0;
                status_flags[`MMNX_FLAG_DC] <= opnd_reg[3:0] == 4'h0;
                status_flags[`MMNX_FLAG_OV] <= opnd_reg == 8'h80;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_move_write;
        @(posedge clock) disable iff (srst)
        (clk_en && phase_reg == MMNX_Q3 && op_reg == MMNX_MOVE) |=>
            (mem_req.we && mem_req.wdata == $past(acc_reg));
    endproperty
    a_move_write: assert property (p_move_write) else $error("move write wrong");

    property p_bank_sel;
        @(posedge clock) disable iff (srst)
        (clk_en && phase_reg == MMNX_Q1 && instr_valid && op_dec != MMNX_NONE
            && instr_word[8]) |=> mem_req.addr == {$past(bank_select_reg), $past(instr_word[7:0])};
    endproperty
    a_bank_sel: assert property (p_bank_sel) else $error("bank address wrong");

    property p_indexed;
        @(posedge clock) disable iff (srst)
        (clk_en && phase_reg == MMNX_Q1 && instr_valid && op_dec != MMNX_NONE && !instr_word[8]
            && ext_set_en && instr_word[7:0] <= `MMNX_INDEXED_MAX)
            |=> mem_req.addr == $past(index_base) + {4'h0, $past(instr_word[7:0])};
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_mul_prod;
        @(posedge clock) disable iff (srst)
        (clk_en && mul_load) |=> prod == $past(acc_reg) * $past(opnd_reg);
    endproperty
    a_mul_prod: assert property (p_mul_prod) else $error("product wrong");

    property p_mul_noflag;
        @(posedge clock) disable iff (srst)
        (op_reg == MMNX_MULL || op_reg == MMNX_MULF) && busy |-> ##1 status_we == 5'h00;
    endproperty
    a_mul_noflag: assert property (p_mul_noflag) else $error("multiply touched flags");

    property p_mulf_nowrite;
        @(posedge clock) disable iff (srst)
        (op_reg == MMNX_MULF && busy) |-> !mem_req.we;
    endproperty
    a_mulf_nowrite: assert property (p_mulf_nowrite) else $error("multiply wrote memory");

    property p_zero_kept;
        @(posedge clock) disable iff (srst)
        (product_we && prod == '0) |-> status_we[`MMNX_FLAG_Z] == 1'b0;
    endproperty
    a_zero_kept: assert property (p_zero_kept) else $error("zero flagged");

    property p_neg;
        @(posedge clock) disable iff (srst)
        (clk_en && phase_reg == MMNX_Q3 && op_reg == MMNX_NEG)
            |=> mem_req.we && mem_req.wdata == 8'h00 - $past(opnd_reg) && status_we == 5'h1f;
    endproperty
    a_neg: assert property (p_neg) else $error("negate wrong");

    property p_four_phase;
        @(posedge clock) disable iff (srst)
        ($rose(busy) && clk_en) |-> busy [*3] ##1 (!busy || !clk_en);
    endproperty
    a_four_phase: assert property (p_four_phase) else $error("cycle length wrong");
endmodule
`default_nettype wire

// file: sim/tb.sv
`default_nettype none
module tb import mmnx_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // stimulus rows
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] iw;
        logic [7:0] acc;
        logic [7:0] mem;
        logic [3:0] bank;
        logic ext;
        logic [11:0] base;
    } mmnx_row_t;
    mmnx_row_t rows [15] = '{
        '{16'h6e20, 8'h4f, 8'hff, 4'h0, 1'b0, 12'h000},
        '{16'h6e80, 8'h11, 8'h00, 4'h0, 1'b0, 12'h000},
        '{16'h6f10, 8'h22, 8'h00, 4'h5, 1'b0, 12'h000},
        '{16'h6e5f, 8'h33, 8'h00, 4'h0, 1'b1, 12'h100},
        '{16'h6e60, 8'h44, 8'h00, 4'h0, 1'b1, 12'h100},
        '{16'h6f05, 8'h55, 8'h00, 4'h3, 1'b1, 12'h100},
        '{16'h6c40, 8'h00, 8'h3a, 4'h0, 1'b0, 12'h000},
        '{16'h6c41, 8'h00, 8'h80, 4'h0, 1'b0, 12'h000},
        '{16'h0dc4, 8'he2, 8'h00, 4'h0, 1'b0, 12'h000},
        '{16'h0d00, 8'h55, 8'h00, 4'h0, 1'b0, 12'h000},
        '{16'h6d07, 8'h00, 8'h00, 4'h9, 1'b0, 12'h000},
        '{16'h0333, 8'hc4, 8'hb5, 4'h2, 1'b0, 12'h000},
        '{16'h0200, 8'hff, 8'hff, 4'h0, 1'b1, 12'h200},
        '{16'h6c10, 8'h00, 8'h01, 4'h0, 1'b1, 12'h0ff},
        '{16'h0290, 8'h00, 8'h7f, 4'h0, 1'b1, 12'h000}
    };
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [7:0] acc = 8'h00;
    logic [7:0] mem_rdata = 8'h00;
    logic [3:0] bank_select_reg = 4'h0;
    logic ext_set_en = 1'b0;
    logic [11:0] index_base = 12'h000;
    logic busy, done, unsupported, product_we;
    mmnx_mem_req_t mem_req;
    logic [7:0] product_high_byte, product_low_byte;
    logic [4:0] status_flags, status_we;
    logic [15:0] exp_prod = 16'h0000;
    logic [4:0] exp_flags = 5'h00;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    mmnx_exec uut (.clock(clock), .srst(srst), .clk_en(clk_en), .instr_valid(instr_valid),
        .instr_word(instr_word), .acc(acc), .bank_select_reg(bank_select_reg),
        .ext_set_en(ext_set_en), .index_base(index_base), .mem_rdata(mem_rdata), .busy(busy),
        .done(done), .unsupported(unsupported), .mem_req(mem_req),
        .product_high_byte(product_high_byte), .product_low_byte(product_low_byte),
        .product_we(product_we), .status_flags(status_flags), .status_we(status_we));
    initial begin
        forever #20 clock = ~clock;
    end
    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run;
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ceiling well above 15 rows of a few cycles each
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            complete_run;
        end
    end
    // ----------------------------------------
    // one instruction; stall freezes clk_en, intrude offers a word while busy
    // ----------------------------------------
    task automatic run_op(input mmnx_row_t r, input int stall, input bit intrude);
        logic [11:0] ea;
        logic [7:0] f, res;
        bit mv, ng, ml, mf;
        int n;
        f = r.iw[7:0];
        mv = r.iw[15:9] == 7'h37;
        ng = r.iw[15:9] == 7'h36;
        mf = r.iw[15:9] == 7'h01;
        ml = r.iw[15:8] == 8'h0d;
        if (r.iw[8]) ea = {r.bank, f};
        else if (r.ext && f <= 8'h5f) ea = r.base + {4'h0, f};
        else ea = {(f < 8'h60) ? 4'h0 : 4'hf, f};
        res = ~r.mem + 8'h01;
        if (ng) exp_flags = {res[7], r.mem == 8'h80, res == 8'h00, r.mem[3:0] == 4'h0,
            r.mem == 8'h00};
        if (ml || mf) exp_prod = {8'h00, r.acc} * {8'h00, ml ? f : r.mem};
        @(posedge clock);
        instr_word <= r.iw;
        acc <= r.acc;
        mem_rdata <= r.mem;
        bank_select_reg <= r.bank;
        ext_set_en <= r.ext;
        index_base <= r.base;
        instr_valid <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            instr_valid <= intrude && n == 1;
            if (intrude && n == 1) instr_word <= 16'h0d03;
            clk_en <= n < 1 || n >= 1 + stall;
            #1;
            if (n == 0) chk("read_en", 16'(mem_req.re), 16'(ng || mf));
            if (mem_req.re && !ml) chk("read_addr", 16'(mem_req.addr), 16'(ea));
            if (done) break;
        end
        chk("done", 16'(done), 16'h0001);
        // done lands in the fourth phase, two enabled edges after acceptance
        chk("phases", 16'(n), 16'(2 + stall));
        chk("busy_q4", 16'(busy), 16'h0001);
        chk("mem_we", 16'(mem_req.we), 16'(mv || ng));
        if (mv || ng) chk("write_addr", 16'(mem_req.addr), 16'(ea));
        if (mv) chk("wdata", 16'(mem_req.wdata), 16'(r.acc));
        if (ng) chk("wdata", 16'(mem_req.wdata), 16'(res));
        chk("product_we", 16'(product_we), 16'(ml || mf));
        chk("product", {product_high_byte, product_low_byte}, exp_prod);
        chk("status_we", 16'(status_we), ng ? 16'h001f : 16'h0000);
        chk("flags", 16'(status_flags), 16'(exp_flags));
        // strobes stand for one enabled cycle only
        @(posedge clock);
        #1;
        chk("busy_end", 16'(busy), 16'h0000);
        chk("pulse_end", 16'({done, mem_req.we, product_we, status_we}), 16'h0000);
        // a word offered while busy must not start a second operation
        if (intrude) repeat (6) begin
            @(posedge clock);
            #1;
            chk("refused", 16'(done), 16'h0000);
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        #1;
        chk("reset_out", 16'({status_flags, status_we, busy, done, product_we, mem_req.we}),
            16'h0000);
        foreach (rows[i]) run_op(rows[i], 0, 1'b0);
        run_op(rows[11], 5, 1'b0);
        run_op(rows[8], 0, 1'b1);
        // an undecoded word starts nothing and is flagged for one cycle
        @(posedge clock);
        instr_word <= 16'h0000;
        instr_valid <= 1'b1;
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
        chk("unsupported", 16'(unsupported), 16'h0001);
        chk("no_start", 16'(busy), 16'h0000);
        @(posedge clock);
        #1;
        chk("unsup_end", 16'(unsupported), 16'h0000);
        // reset in mid-instruction abandons it; held two edges so no check sees a cut cycle
        @(posedge clock);
        instr_word <= 16'h6c40;
        mem_rdata <= 8'h3a;
        instr_valid <= 1'b1;
        @(posedge clock);
        instr_valid <= 1'b0;
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        #1;
        chk("reset_mid", 16'({status_flags, status_we, busy, done}), 16'h0000);
        chk("reset_strobes", 16'({product_we, mem_req.we, mem_req.re, unsupported}), 16'h0000);
        chk("reset_prod", {product_high_byte, product_low_byte}, 16'h0000);
        exp_prod = 16'h0000;
        exp_flags = 5'h00;
        run_op(rows[11], 0, 1'b0);
        complete_run;
    end
endmodule
`default_nettype wire
